/* File: core/asb_pkg.sv */
/*
  Package for the axis stop, brake and fault sequencer.
  Holds register offsets, field positions, reset values, fault group codes,
  timing constants and the axis state type.
  Assumes a 10 MHz APB clock and two axes.
*/
package asb_pkg;

  localparam int NUM_AXES = 2;
  localparam int SLOTS = 4;
  localparam int ENTRIES = SLOTS + 1;
  localparam int LIST_LEN = NUM_AXES * ENTRIES;

  // Timing
  localparam int CLK_PERIOD_NS = 100;
  localparam int TICK_TIME_NS = 1000000;
  localparam int TICK_CYCLES = TICK_TIME_NS / CLK_PERIOD_NS;

  // Drive-wide register offsets
  localparam logic [11:0] OFS_DRV_CTRL = 12'h000;
  localparam logic [11:0] OFS_DRV_STATUS = 12'h004;
  localparam logic [11:0] OFS_DISPLAY = 12'h008;
  localparam logic [11:0] OFS_DRV_WARN = 12'h00C;
  localparam logic [11:0] OFS_LIST_INDEX = 12'h010;
  localparam logic [11:0] OFS_LIST_ENTRY = 12'h014;

  // Per-axis block: base = AXIS_STRIDE * (axis + 1)
  localparam logic [11:0] AXIS_STRIDE = 12'h040;
  localparam logic [5:0] OFS_AX_CTRL = 6'h00;
  localparam logic [5:0] OFS_AX_ZSPEED = 6'h04;
  localparam logic [5:0] OFS_AX_ZTIME = 6'h08;
  localparam logic [5:0] OFS_AX_STATUS = 6'h0C;
  localparam logic [5:0] OFS_AX_FAULT0 = 6'h10;
  localparam logic [5:0] OFS_AX_WARN = 6'h24;

  // Field positions
  localparam int DRV_UVMODE_BIT = 0;
  localparam int AX_ENABLE_BIT = 0;
  localparam int AX_DISMODE_LSB = 1;
  localparam int AX_BRAKEIMM_BIT = 3;
  localparam int AX_CLEAR_BIT = 4;

  // Reset values
  localparam logic RST_UVMODE = 1'b1;
  localparam logic [1:0] RST_DISMODE = 2'h0;
  localparam logic [15:0] RST_ZSPEED = 16'h0064;
  localparam logic [15:0] RST_ZTIME = 16'h03E8;

  // Mode values
  localparam logic [1:0] DISMODE_CONTROLLED = 2'h2;
  localparam logic [1:0] RESP_IMMEDIATE = 2'h0;
  localparam logic [1:0] RESP_DYNAMIC = 2'h1;

  // Fault and warning group codes, two BCD digits
  localparam logic [7:0] GRP_SYSTEM = 8'h10;
  localparam logic [7:0] GRP_FILE = 8'h11;
  localparam logic [7:0] GRP_HARDWARE = 8'h15;
  localparam logic [7:0] GRP_POWER = 8'h20;
  localparam logic [7:0] GRP_TEMPERATURE = 8'h25;
  localparam logic [7:0] GRP_SOFTWARE = 8'h30;
  localparam logic [7:0] GRP_FEEDBACK = 8'h40;
  localparam logic [7:0] GRP_MOTOR = 8'h50;
  localparam logic [7:0] GRP_WAKE_SHAKE = 8'h55;
  localparam logic [7:0] GRP_MOTION = 8'h60;
  localparam logic [7:0] GRP_FIELDBUS = 8'h70;
  localparam logic [7:0] GRP_SAFETY = 8'h90;
  localparam logic [7:0] ID_UNDERVOLTAGE = 8'h07;
  localparam logic [15:0] CODE_UNDERVOLTAGE = {GRP_POWER, ID_UNDERVOLTAGE};
  localparam logic [7:0] LIST_DASH = 8'h2D;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_RUN = 3'b001,
    ST_DECEL = 3'b010,
    ST_DYNBRK = 3'b011,
    ST_COAST = 3'b100
  } asb_state_type;

endpackage

/* File: core/asb_sequencer.sv */
/*
  Axis stop, brake and fault sequencer with an APB register slave.
  Assumes all inputs synchronous to pclk, speed magnitudes unsigned,
  and fault codes given as two BCD digit group plus two BCD digit id.
*/
// Design decisions made here: the APB interface to the registers and the address map.
// What this block does
// - Mode 0: undervoltage always raises fault
// - Mode 1: warn if disabled, else fault
// - Brake on zero speed or timeout
// - Power removal leads to brake engage
// - Brake-immediate option after fault or hard off (enable removal, torque-off)
// - Hardware enable removal cuts power on the next clock
// - Disable mode 0: immediate axis disable
// - Disable mode 2: controlled stop first
// - Torque-off cuts power, uncontrolled stop
// - Stop input: controlled stop, then brake
// - Fault relay follows fault state
// - Per-fault response: off, dynamic, controlled
// - Codes are group digits plus id
// - Fixed group code table
// - Per-axis fault list and single warning register
// - Drive list entry: axis, dash, code
`timescale 1ns/100ps
`default_nettype none

module asb_sequencer #(
  parameter int TICK_DIV = asb_pkg::TICK_CYCLES
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [asb_pkg::NUM_AXES-1:0] hw_enable,
  input wire logic [asb_pkg::NUM_AXES-1:0] torque_off_request,
  input wire logic [asb_pkg::NUM_AXES-1:0] stop_input,
  input wire logic [16*asb_pkg::NUM_AXES-1:0] speed_magnitude,
  input wire logic bus_undervoltage,
  input wire logic [asb_pkg::NUM_AXES-1:0] fault_valid,
  input wire logic [8*asb_pkg::NUM_AXES-1:0] fault_group,
  input wire logic [8*asb_pkg::NUM_AXES-1:0] fault_id,
  input wire logic [2*asb_pkg::NUM_AXES-1:0] fault_response,
  input wire logic [asb_pkg::NUM_AXES-1:0] warn_valid,
  input wire logic [16*asb_pkg::NUM_AXES-1:0] warn_code,
  output logic [asb_pkg::NUM_AXES-1:0] axis_power_active,
  output logic [asb_pkg::NUM_AXES-1:0] decel_request,
  output logic [asb_pkg::NUM_AXES-1:0] dyn_brake_request,
  output logic [asb_pkg::NUM_AXES-1:0] brake_engage,
  output logic fault_relay_output,
  output logic [15:0] display_code
);
  import asb_pkg::*;

  //////////////////////////////////////////////////////////////////////////
  // Bus decode and millisecond tick
  wire logic bus_wr = psel & penable & pwrite;
  wire logic bus_setup = psel & ~penable;
  wire logic drv_ctrl_hit = (paddr == OFS_DRV_CTRL);
  wire logic drv_hit = drv_ctrl_hit | (paddr == OFS_DRV_STATUS) | (paddr == OFS_DISPLAY)
    | (paddr == OFS_DRV_WARN) | (paddr == OFS_LIST_INDEX) | (paddr == OFS_LIST_ENTRY);
  logic [NUM_AXES-1:0] ax_hit;
  logic [31:0] ax_rdata [0:NUM_AXES-1];
  logic [NUM_AXES-1:0] disp_evt;
  logic [15:0] disp_code [0:NUM_AXES-1];
  logic [NUM_AXES-1:0] ax_fault_any;
  logic [NUM_AXES-1:0] ax_enabled;
  logic [15:0] list_code [0:LIST_LEN-1];
  logic [LIST_LEN-1:0] list_valid;

  logic uvmode_ff;
  logic uv_prev_ff;
  logic [3:0] list_index_ff;
  logic [15:0] drv_warn_ff;
  logic [15:0] display_ff;
  logic relay_ff;
  logic [31:0] prdata_ff;
  logic [13:0] tick_cnt_ff;
  logic tick_ff;

  wire logic uv_rise = bus_undervoltage & ~uv_prev_ff;
  wire logic [13:0] tick_last = 14'(TICK_DIV - 1);
  wire logic [7:0] sel_axis = 8'(32'(list_index_ff) / ENTRIES + 1);
  wire logic sel_valid = (32'(list_index_ff) < LIST_LEN) ? list_valid[list_index_ff] : 1'b0;
  wire logic [31:0] list_entry = sel_valid
    ? {sel_axis, LIST_DASH, list_code[list_index_ff]} : 32'h0000_0000;
  wire logic mapped = drv_hit | (|ax_hit);
  wire logic drv_uv_warn = bus_undervoltage & uvmode_ff & ~(|ax_enabled);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tick_cnt_ff <= 14'h0000;
      tick_ff <= 1'b0;
    end else begin
      tick_ff <= (tick_cnt_ff == tick_last);
      tick_cnt_ff <= (tick_cnt_ff == tick_last) ? 14'h0000 : tick_cnt_ff + 14'h0001;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Drive-wide registers
  logic [31:0] drv_rdata;
  always_comb begin
    drv_rdata = 32'h0000_0000;
    case (paddr)
      OFS_DRV_CTRL: drv_rdata = {31'h0000_0000, uvmode_ff};
      OFS_DRV_STATUS: drv_rdata = {29'h0000_0000, drv_uv_warn, bus_undervoltage, relay_ff};
      OFS_DISPLAY: drv_rdata = {16'h0000, display_ff};
      OFS_DRV_WARN: drv_rdata = {16'h0000, drv_warn_ff};
      OFS_LIST_INDEX: drv_rdata = {28'h000_0000, list_index_ff};
      OFS_LIST_ENTRY: drv_rdata = list_entry;
      default: drv_rdata = 32'h0000_0000;
    endcase
  end

  logic [31:0] rd_mux;
  logic [15:0] nxt_display;
  always_comb begin
    rd_mux = drv_rdata;
    nxt_display = display_ff;
    for (int a = NUM_AXES - 1; a >= 0; a--) begin
      if (ax_hit[a]) begin
        rd_mux = ax_rdata[a];
      end
      if (disp_evt[a]) begin
        nxt_display = disp_code[a];
      end
    end
    if (drv_uv_warn & (drv_warn_ff != CODE_UNDERVOLTAGE) & ~(|disp_evt)) begin
      nxt_display = CODE_UNDERVOLTAGE;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      uvmode_ff <= RST_UVMODE;
      uv_prev_ff <= 1'b0;
      list_index_ff <= 4'h0;
      drv_warn_ff <= 16'h0000;
      display_ff <= 16'h0000;
      relay_ff <= 1'b0;
      prdata_ff <= 32'h0000_0000;
    end else begin
      uv_prev_ff <= bus_undervoltage;
      if (bus_wr & drv_ctrl_hit) begin
        uvmode_ff <= pwdata[DRV_UVMODE_BIT];
      end
      if (bus_wr & (paddr == OFS_LIST_INDEX)) begin
        list_index_ff <= pwdata[3:0];
      end
      drv_warn_ff <= drv_uv_warn ? CODE_UNDERVOLTAGE : 16'h0000;
      display_ff <= nxt_display;
      relay_ff <= |ax_fault_any;
      if (bus_setup & ~pwrite) begin
        prdata_ff <= rd_mux;
      end
    end
  end

  assign prdata = prdata_ff;
  assign pready = 1'b1;
  assign pslverr = psel & penable & ~mapped;
  assign fault_relay_output = relay_ff;
  assign display_code = display_ff;

  //////////////////////////////////////////////////////////////////////////
  // Per-axis sequencer, fault list and registers
  for (genvar a = 0; a < NUM_AXES; a++) begin : g_axis
    localparam logic [11:0] BASE = 12'(AXIS_STRIDE * (a + 1));
    wire logic blk_hit = (paddr[11:6] == BASE[11:6]);
    wire logic [5:0] ofs = paddr[5:0];
    assign ax_hit[a] = blk_hit & ((ofs <= OFS_AX_WARN) & (ofs[1:0] == 2'b00));
    wire logic ctrl_wr = bus_wr & blk_hit & (ofs == OFS_AX_CTRL);

    logic en_ff;
    logic [1:0] dismode_ff;
    logic brakeimm_ff;
    logic [15:0] zspeed_ff;
    logic [15:0] ztime_ff;
    logic [15:0] timer_ff;
    logic brake_ff;
    logic uv_fault_ff;
    logic [15:0] warn_ff;
    logic [SLOTS-1:0] slot_valid_ff;
    logic [15:0] slot_code_ff [0:SLOTS-1];
    asb_state_type state_ff;
    asb_state_type nxt_state;
    logic nxt_brake;

    wire logic clear = ctrl_wr & pwdata[AX_CLEAR_BIT];
    wire logic axis_disable_cmd = ctrl_wr & ~pwdata[AX_ENABLE_BIT] & en_ff;
    wire logic enable_attempt = ctrl_wr & pwdata[AX_ENABLE_BIT] & ~en_ff;
    wire logic [15:0] fcode = {fault_group[8*a+:8], fault_id[8*a+:8]};
    wire logic [1:0] fresp = fault_response[2*a+:2];
    wire logic hard_off = ~hw_enable[a] | torque_off_request[a];
    wire logic running = (state_ff == ST_RUN) | (state_ff == ST_DECEL);
    wire logic at_zero = speed_magnitude[16*a+:16] < zspeed_ff;
    wire logic timed_out = timer_ff >= ztime_ff;
    wire logic stop_done = at_zero | timed_out;
    wire logic uv_set = uvmode_ff
      ? (bus_undervoltage & (running | enable_attempt))
      : uv_rise;
    wire logic flt_new = fault_valid[a] | uv_set;
    wire logic [1:0] resp = fault_valid[a] ? fresp : RESP_IMMEDIATE;
    assign ax_enabled[a] = running;
    assign ax_fault_any[a] = (|slot_valid_ff) | uv_fault_ff;
    assign list_code[a*ENTRIES+SLOTS] = CODE_UNDERVOLTAGE;
    assign list_valid[a*ENTRIES+SLOTS] = uv_fault_ff;
    for (genvar s = 0; s < SLOTS; s++) begin : g_list
      assign list_code[a*ENTRIES+s] = slot_code_ff[s];
      assign list_valid[a*ENTRIES+s] = slot_valid_ff[s];
    end

    // Fault list insert: clear first, then a new code takes lowest free slot
    logic [SLOTS-1:0] nxt_valid;
    logic [1:0] free_idx;
    logic have_free;
    logic dup;
    always_comb begin
      nxt_valid = clear ? {SLOTS{1'b0}} : slot_valid_ff;
      free_idx = 2'h0;
      have_free = 1'b0;
      dup = 1'b0;
      for (int s = SLOTS - 1; s >= 0; s--) begin
        if (!nxt_valid[s]) begin
          free_idx = 2'(s);
          have_free = 1'b1;
        end
        if (nxt_valid[s] & (slot_code_ff[s] == fcode)) begin
          dup = 1'b1;
        end
      end
    end
    wire logic do_insert = fault_valid[a] & ~dup & have_free;
    assign disp_evt[a] = do_insert | (uv_set & (~uv_fault_ff | clear))
      | (warn_valid[a] & (warn_code[16*a+:16] != warn_ff));
    assign disp_code[a] = do_insert ? fcode
      : ((uv_set & (~uv_fault_ff | clear)) ? CODE_UNDERVOLTAGE : warn_code[16*a+:16]);

    always_comb begin
      nxt_state = state_ff;
      nxt_brake = brake_ff;
      case (state_ff)
        ST_IDLE: begin
          nxt_brake = 1'b1;
          if (en_ff & ~hard_off & ~ax_fault_any[a] & ~flt_new & ~stop_input[a]
              & ~(uvmode_ff & bus_undervoltage)) begin
            nxt_state = ST_RUN;
            nxt_brake = 1'b0;
          end
        end
        ST_RUN: begin
          if (hard_off) begin
            nxt_state = ST_COAST;
            nxt_brake = brakeimm_ff;
          end else if (flt_new) begin
            nxt_brake = brakeimm_ff;
            if (resp == RESP_IMMEDIATE) begin
              nxt_state = ST_COAST;
            end else if (resp == RESP_DYNAMIC) begin
              nxt_state = ST_DYNBRK;
            end else begin
              nxt_state = ST_DECEL;
            end
          end else if (stop_input[a]) begin
            nxt_state = ST_DECEL;
          end else if (axis_disable_cmd) begin
            nxt_state = (dismode_ff == DISMODE_CONTROLLED) ? ST_DECEL : ST_COAST;
          end
        end
        ST_DECEL: begin
          if (hard_off | (flt_new & (resp == RESP_IMMEDIATE))) begin
            nxt_state = ST_COAST;
            nxt_brake = brakeimm_ff;
          end else if (stop_done) begin
            nxt_state = ST_IDLE;
            nxt_brake = 1'b1;
          end
        end
        ST_DYNBRK, ST_COAST: begin
          if (stop_done) begin
            nxt_state = ST_IDLE;
            nxt_brake = 1'b1;
          end
        end
        default: begin
          nxt_state = ST_IDLE;
          nxt_brake = 1'b1;
        end
      endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        state_ff <= ST_IDLE;
        brake_ff <= 1'b1;
        timer_ff <= 16'h0000;
      end else begin
        state_ff <= nxt_state;
        brake_ff <= nxt_brake;
        if ((state_ff == ST_IDLE) | (state_ff == ST_RUN)) begin
          timer_ff <= 16'h0000;
        end else if (tick_ff & (timer_ff != 16'hFFFF)) begin
          timer_ff <= timer_ff + 16'h0001;
        end
      end
    end

    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        en_ff <= 1'b0;
        dismode_ff <= RST_DISMODE;
        brakeimm_ff <= 1'b0;
        zspeed_ff <= RST_ZSPEED;
        ztime_ff <= RST_ZTIME;
        uv_fault_ff <= 1'b0;
        warn_ff <= 16'h0000;
        slot_valid_ff <= {SLOTS{1'b0}};
        for (int s = 0; s < SLOTS; s++) begin
          slot_code_ff[s] <= 16'h0000;
        end
      end else begin
        if (ctrl_wr) begin
          en_ff <= pwdata[AX_ENABLE_BIT];
          dismode_ff <= pwdata[AX_DISMODE_LSB+:2];
          brakeimm_ff <= pwdata[AX_BRAKEIMM_BIT];
        end
        if (bus_wr & blk_hit & (ofs == OFS_AX_ZSPEED)) begin
          zspeed_ff <= pwdata[15:0];
        end
        if (bus_wr & blk_hit & (ofs == OFS_AX_ZTIME)) begin
          ztime_ff <= pwdata[15:0];
        end
        uv_fault_ff <= uv_set | (uv_fault_ff & ~clear);
        if (warn_valid[a]) begin
          warn_ff <= warn_code[16*a+:16];
        end else if (clear) begin
          warn_ff <= 16'h0000;
        end
        slot_valid_ff <= nxt_valid;
        if (do_insert) begin
          slot_valid_ff[free_idx] <= 1'b1;
          slot_code_ff[free_idx] <= fcode;
        end
      end
    end

    always_comb begin
      ax_rdata[a] = 32'h0000_0000;
      if (ofs == OFS_AX_CTRL) begin
        ax_rdata[a] = {28'h000_0000, brakeimm_ff, dismode_ff, en_ff};
      end else if (ofs == OFS_AX_ZSPEED) begin
        ax_rdata[a] = {16'h0000, zspeed_ff};
      end else if (ofs == OFS_AX_ZTIME) begin
        ax_rdata[a] = {16'h0000, ztime_ff};
      end else if (ofs == OFS_AX_STATUS) begin
        ax_rdata[a] = {16'h0000, timer_ff[7:0], uv_fault_ff, slot_valid_ff, state_ff};
      end else if (ofs == OFS_AX_WARN) begin
        ax_rdata[a] = {16'h0000, warn_ff};
      end else if (ofs >= OFS_AX_FAULT0) begin
        ax_rdata[a] = list_valid[a*ENTRIES+32'(ofs[5:2]-4'h4)]
          ? {16'h0000, list_code[a*ENTRIES+32'(ofs[5:2]-4'h4)]} : 32'h0000_0000;
      end
    end

    assign axis_power_active[a] = running;
    assign decel_request[a] = (state_ff == ST_DECEL);
    assign dyn_brake_request[a] = (state_ff == ST_DYNBRK);
    assign brake_engage[a] = brake_ff;
  end

endmodule

`default_nettype wire

/* File: testbench/asb_seq_props.sv */
/*
  Checker for the axis stop, brake and fault sequencer ports.
  Assumes the zero-speed threshold stays at its reset value.
*/
`timescale 1ns/100ps
`default_nettype none

module asb_seq_props (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pslverr,
  input wire logic [1:0] hw_enable,
  input wire logic [1:0] torque_off_request,
  input wire logic [1:0] stop_input,
  input wire logic [31:0] speed_magnitude,
  input wire logic bus_undervoltage,
  input wire logic [1:0] fault_valid,
  input wire logic [3:0] fault_response,
  input wire logic [1:0] axis_power_active,
  input wire logic [1:0] decel_request,
  input wire logic [1:0] dyn_brake_request,
  input wire logic [1:0] brake_engage,
  input wire logic fault_relay_output
);
  localparam logic [15:0] ZS = 16'h0064;
  wire logic run0 = axis_power_active[0] & ~decel_request[0];
  wire logic run1 = axis_power_active[1] & ~decel_request[1];
  wire logic slow0 = speed_magnitude[15:0] < ZS;
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  //////////////////////////////////////////////////////////////////////////////
  hw_off_cut_a: assert property (run0 && !hw_enable[0] |=> !axis_power_active[0])
    else $error("Power stayed on after hardware enable removal");
  sto_cut_a: assert property (run0 && torque_off_request[0] |=> !axis_power_active[0])
    else $error("Power stayed on after torque-off request");
  stop_decel_a: assert property (run0 && stop_input[0] && hw_enable[0]
    && !torque_off_request[0] && !fault_valid[0] && !bus_undervoltage |=> decel_request[0])
    else $error("Stop input did not start a controlled stop");
  zero_brake_a: assert property ((decel_request[0]
    || !axis_power_active[0] && !brake_engage[0]) && slow0 |=> brake_engage[0])
    else $error("Brake not applied at zero speed");
  off_brake_a: assert property ($fell(axis_power_active[0]) && slow0
    |-> ##[0:1] brake_engage[0])
    else $error("Brake not applied after power removal");
  relay_set_a: assert property (|fault_valid |-> ##2 fault_relay_output)
    else $error("Fault relay not driven after a fault");
  fault_off_a: assert property (run1 && fault_valid[1] && fault_response[3:2] == 2'h0
    |=> !axis_power_active[1] && !dyn_brake_request[1])
    else $error("Immediate-off fault left the stage on");
  fault_dyn_a: assert property (run1 && fault_valid[1] && fault_response[3:2] == 2'h1
    && hw_enable[1] && !torque_off_request[1] |=> dyn_brake_request[1])
    else $error("Dynamic-brake fault did not brake");
  err_phase_a: assert property (pslverr |-> psel && penable)
    else $error("Slave error outside the access phase");
endmodule

bind asb_sequencer asb_seq_props asb_seq_props_inst (.*);

`default_nettype wire

/* File: testbench/asb_motor_model.sv */
/*
  Motor and power stage model: speed follows power, decel and brake.
  Assumes two axes; coasting is slow, braked decel is fast.
*/
`timescale 1ns/100ps
`default_nettype none

module asb_motor_model (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [1:0] axis_power_active,
  input wire logic [1:0] decel_request,
  input wire logic [1:0] dyn_brake_request,
  input wire logic [1:0] brake_engage,
  output logic [31:0] speed_magnitude
);
  logic [15:0] speed_ff [2];
  logic [15:0] nxt_speed [2];
  for (genvar a = 0; a < 2; a++) begin : g_ax
    logic [15:0] step;
    // Driven motor runs at speed; otherwise it slows down
    assign step = (decel_request[a] | dyn_brake_request[a]) ? 16'h0040 : 16'h0010;
    assign nxt_speed[a] = (axis_power_active[a] && !decel_request[a]) ? 16'h0200 :
      (brake_engage[a] || speed_ff[a] < step) ? 16'h0000 : speed_ff[a] - step;
    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        speed_ff[a] <= 16'h0000;
      end else begin
        speed_ff[a] <= nxt_speed[a];
      end
    end
    assign speed_magnitude[16*a +: 16] = speed_ff[a];
  end
endmodule

`default_nettype wire

/* File: testbench/axis_stop_brake_fault_sequencer_tb_top.sv */
/*
  Bench for the axis stop, brake and fault sequencer: APB host and stimulus.
  Assumes the millisecond tick shortened to 4 clocks.
*/
`timescale 1ns/100ps
`default_nettype none

module axis_stop_brake_fault_sequencer_tb_top;
  import asb_pkg::*;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, bus_undervoltage = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, warn_code = 32'h0, prdata, speed_magnitude, rd;
  logic pready, pslverr, fault_relay_output, err;
  logic [1:0] hw_enable = 2'h3, torque_off_request = 2'h0, stop_input = 2'h0;
  logic [1:0] fault_valid = 2'h0, warn_valid = 2'h0;
  logic [15:0] fault_group = 16'h0, fault_id = 16'h0, display_code;
  logic [3:0] fault_response = 4'h0;
  logic [1:0] axis_power_active, decel_request, dyn_brake_request, brake_engage;
  int failures = 0;
  int check_count = 0;
  always #50 pclk = ~pclk;
  asb_sequencer #(.TICK_DIV(4)) asb_sequencer_inst (.*);
  asb_motor_model asb_motor_model_inst (.*);
  //////////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      failures++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic conclude;
    $display("Checks %0d, mismatches %0d", check_count, failures);
    if (failures == 0 && check_count > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  task automatic xfer(input logic [11:0] a, input logic w, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) begin
      @(posedge pclk);
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic rchk(input logic [11:0] a, input logic [31:0] exp);
    xfer(a, 1'b0, 32'h0);
    chk(rd, exp);
  endtask
  task automatic edges(input int k);
    repeat (k) @(posedge pclk);
    @(negedge pclk);
  endtask
  task automatic wait_brake(input int a, output int n);
    n = 0;
    while (brake_engage[a] !== 1'b1 && n < 60) begin
      @(negedge pclk);
      n++;
    end
  endtask
  task automatic run_axis(input int a, input logic [31:0] c);
    xfer(12'(64 * (a + 1)), 1'b1, c);
    edges(2);
    chk(axis_power_active[a], 1'b1);
  endtask
  task automatic fault(input logic [15:0] c, input logic [1:0] r);
    @(posedge pclk);
    fault_valid <= 2'h2;
    fault_group <= {2{c[15:8]}};
    fault_id <= {2{c[7:0]}};
    fault_response <= {2{r}};
    @(posedge pclk);
    fault_valid <= 2'h0;
  endtask
  //////////////////////////////////////////////////////////////////////////////
  task automatic t_regs;
    chk(brake_engage, 2'h3);
    rchk(12'h000, 32'h1);
    chk(err, 1'b0);
    rchk(12'h044, 32'h64);
    rchk(12'h048, 32'h3E8);
    rchk(12'hFFC, 32'h0);
    chk(err, 1'b1);
    xfer(12'h048, 1'b1, 32'h3);
    xfer(12'h088, 1'b1, 32'h3);
    @(posedge pclk);
    warn_valid <= 2'h1;
    warn_code <= 32'h2510;
    @(posedge pclk);
    warn_valid <= 2'h0;
    rchk(12'h064, 32'h2510);
    chk(display_code, 16'h2510);
    xfer(12'h040, 1'b1, 32'h10);
    $display("register test done");
  endtask
  task automatic t_stop;
    int n;
    run_axis(0, 32'h1);
    @(posedge pclk);
    stop_input <= 2'h1;
    edges(1);
    chk(decel_request[0], 1'b1);
    wait_brake(0, n);
    chk(axis_power_active[0], 1'b0);
    chk(n < 10, 1'b1);
    edges(2);
    chk(axis_power_active[0], 1'b0);
    xfer(12'h040, 1'b1, 32'h0);
    repeat (20) @(posedge pclk);
    stop_input <= 2'h0;
    $display("stop input test done");
  endtask
  task automatic t_dismode;
    int n;
    for (int m = 0; m <= 2; m += 2) begin
      run_axis(0, 32'(1 + 2 * m));
      xfer(12'h040, 1'b1, 32'(2 * m));
      edges(1);
      chk(decel_request[0], m == 2);
      chk(axis_power_active[0], m == 2);
      wait_brake(0, n);
      chk(n > 2 && n < 16, 1'b1);
    end
    $display("disable mode test done");
  endtask
  task automatic t_hard_off;
    int n;
    for (int s = 0; s < 2; s++) begin
      run_axis(0, s ? 32'h1 : 32'h9);
      @(posedge pclk);
      torque_off_request <= {1'b0, s[0]};
      hw_enable <= {1'b1, s[0]};
      edges(1);
      chk(axis_power_active[0] | decel_request[0], 1'b0);
      chk(brake_engage[0], !s);
      wait_brake(0, n);
      chk(n < 16, 1'b1);
      xfer(12'h040, 1'b1, 32'h0);
      torque_off_request <= 2'h0;
      hw_enable <= 2'h3;
      edges(16);
    end
    $display("hard off test done");
  endtask
  task automatic t_faults;
    int n;
    logic [15:0] c [3] = '{16'h5003, 16'h2502, 16'h6004};
    for (int r = 0; r < 3; r++) begin
      run_axis(1, r == 1 ? 32'h9 : 32'h1);
      fault(c[r], 2'(r));
      edges(0);
      chk(dyn_brake_request[1], r == 1);
      chk(decel_request[1], r == 2);
      chk(brake_engage[1], r == 1);
      edges(1);
      chk(fault_relay_output, 1'b1);
      chk(display_code, c[r]);
      wait_brake(1, n);
      chk(brake_engage[1], 1'b1);
      rchk(12'h090, {16'h0, c[r]});
      xfer(12'h010, 1'b1, 32'h5);
      rchk(12'h014, {16'h022D, c[r]});
      xfer(12'h080, 1'b1, 32'h10);
      edges(2);
      chk(fault_relay_output, 1'b0);
    end
    $display("fault response test done");
  endtask
  task automatic t_groups;
    logic [7:0] g [12] = '{8'h10, 8'h11, 8'h15, 8'h20, 8'h25, 8'h30,
      8'h41, 8'h50, 8'h55, 8'h60, 8'h70, 8'h90};
    for (int i = 0; i < 12; i++) begin
      fault({g[i], 8'h01}, 2'h0);
      if (i % 4 == 3) begin
        for (int k = 0; k < 4; k++) begin
          rchk(12'(144 + 4 * k), {16'h0, g[i - 3 + k], 8'h01});
        end
        xfer(12'h080, 1'b1, 32'h10);
      end
    end
    $display("group code test done");
  endtask
  task automatic t_uv;
    run_axis(1, 32'h1);
    @(posedge pclk);
    bus_undervoltage <= 1'b1;
    edges(2);
    chk(axis_power_active[1], 1'b0);
    rchk(12'h0A0, 32'h2007);
    rchk(12'h060, 32'h0);
    rchk(12'h00C, 32'h2007);
    xfer(12'h040, 1'b1, 32'h1);
    edges(2);
    chk(axis_power_active[0], 1'b0);
    rchk(12'h060, 32'h2007);
    bus_undervoltage <= 1'b0;
    xfer(12'h040, 1'b1, 32'h10);
    xfer(12'h080, 1'b1, 32'h10);
    xfer(12'h000, 1'b1, 32'h0);
    bus_undervoltage <= 1'b1;
    edges(2);
    rchk(12'h060, 32'h2007);
    rchk(12'h0A0, 32'h2007);
    xfer(12'h010, 1'b1, 32'h4);
    rchk(12'h014, 32'h012D2007);
    bus_undervoltage <= 1'b0;
    xfer(12'h000, 1'b1, 32'h1);
    $display("undervoltage test done");
  endtask
  //////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    t_regs();
    t_stop();
    t_dismode();
    t_hard_off();
    t_faults();
    t_groups();
    t_uv();
    conclude();
  end
  initial begin
    repeat (20000) @(posedge pclk);
    failures++;
    conclude();
  end
endmodule

`default_nettype wire
